/* File: src/mtm_pkg.sv */
// constants and types shared by the modulo overflow timer
package mtm_pkg;

  // register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] MTM_OFS_SC   = 8'h00;
  localparam logic [7:0] MTM_OFS_CFG  = 8'h04;
  localparam logic [7:0] MTM_OFS_CNTH = 8'h08;
  localparam logic [7:0] MTM_OFS_CNTL = 8'h0C;
  localparam logic [7:0] MTM_OFS_MODH = 8'h10;
  localparam logic [7:0] MTM_OFS_MODL = 8'h14;

  // timer_status_control_reg field positions
  localparam int MTM_SC_FLAG_BIT    = 7;
  localparam int MTM_SC_IRQEN_BIT   = 6;
  localparam int MTM_SC_RESTART_BIT = 5;
  localparam int MTM_SC_HALT_BIT    = 4;

  // configuration register field positions
  localparam int MTM_CFG_SRC_LSB = 4;
  localparam int MTM_CFG_PS_LSB  = 0;

  // source select encodings
  localparam logic [1:0] MTM_SRC_BUS   = 2'b00;
  localparam logic [1:0] MTM_SRC_FIXED = 2'b01;

  // prescaler: highest legal code and the divide-by-256 mask
  localparam logic [3:0] MTM_PS_MAX  = 4'h8;
  localparam logic [7:0] MTM_PS_MASK_MAX = 8'hFF;

  // values after reset, and the count top used when the modulo is zero
  localparam logic [15:0] MTM_CNT_RST = 16'h0000;
  localparam logic [15:0] MTM_MOD_RST = 16'h0000;
  localparam logic [15:0] MTM_CNT_TOP_FREE = 16'hFFFF;
  localparam logic [7:0]  MTM_PRE_RST = 8'h00;

  // AXI response codes
  localparam logic [1:0] MTM_RESP_OKAY   = 2'b00;
  localparam logic [1:0] MTM_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       halt;
    logic       irq_en;
    logic [1:0] src;
    logic [3:0] ps;
  } mtm_ctrl_t;

  localparam mtm_ctrl_t MTM_CTRL_RST = '{halt: 1'b1, irq_en: 1'b0, src: 2'b00, ps: 4'h0};

endpackage : mtm_pkg

/* File: src/mtm_modulo_timer.sv */
// modulo overflow timer with AXI4-Lite register access
`timescale 1ns/1ns
module mtm_modulo_timer
  import mtm_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              fixed_freq_clock,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   overflow_irq
);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel capture
  logic              aw_held_q;
  logic              w_held_q;
  logic [7:0]        aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane0_q;
  logic              wr_fire;
  logic              aw_hit_ok;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr[7:0];
      s_axi_awready <= 1'b0;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
      end
      s_axi_awready <= !aw_held_q;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      w_held_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane0_q    <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q     <= 1'b1;
      w_data_q     <= s_axi_wdata[7:0];
      w_lane0_q    <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (wr_fire)
      begin
        w_held_q <= 1'b0;
      end
      s_axi_wready <= !w_held_q;
    end
  end

  // only byte lane 0 carries register data; other lanes are ignored
  logic wr_sc;
  logic wr_cfg;
  logic wr_modh;
  logic wr_modl;

  assign wr_sc   = wr_fire && w_lane0_q && (aw_addr_q == MTM_OFS_SC);
  assign wr_cfg  = wr_fire && w_lane0_q && (aw_addr_q == MTM_OFS_CFG);
  assign wr_modh = wr_fire && w_lane0_q && (aw_addr_q == MTM_OFS_MODH);
  assign wr_modl = wr_fire && w_lane0_q && (aw_addr_q == MTM_OFS_MODL);
  assign aw_hit_ok = (aw_addr_q == MTM_OFS_SC) || (aw_addr_q == MTM_OFS_CFG) ||
                     (aw_addr_q == MTM_OFS_CNTH) || (aw_addr_q == MTM_OFS_CNTL) ||
                     (aw_addr_q == MTM_OFS_MODH) || (aw_addr_q == MTM_OFS_MODL);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MTM_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_hit_ok ? MTM_RESP_OKAY : MTM_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state
  mtm_ctrl_t ctrl_q;
  logic      restart;

  assign restart = wr_sc && w_data_q[MTM_SC_RESTART_BIT];

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= MTM_CTRL_RST;
    end
    else
    begin
      if (wr_sc)
      begin
        ctrl_q.halt   <= w_data_q[MTM_SC_HALT_BIT];
        ctrl_q.irq_en <= w_data_q[MTM_SC_IRQEN_BIT];
      end
      if (wr_cfg)
      begin
        ctrl_q.src <= w_data_q[MTM_CFG_SRC_LSB +: 2];
        ctrl_q.ps  <= w_data_q[MTM_CFG_PS_LSB +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection; the fixed clock is a pin, so it is synchronised
  logic fx_s1_q;
  logic fx_s2_q;
  logic fx_s3_q;
  logic src_tick;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fx_s1_q <= 1'b0;
      fx_s2_q <= 1'b0;
      fx_s3_q <= 1'b0;
    end
    else
    begin
      fx_s1_q <= fixed_freq_clock;
      fx_s2_q <= fx_s1_q;
      fx_s3_q <= fx_s2_q;
    end
  end

  // fixed clock must run below half the bus clock to be seen
  always_comb
  begin
    unique case (ctrl_q.src)
      MTM_SRC_BUS:   src_tick = 1'b1;
      MTM_SRC_FIXED: src_tick = fx_s2_q && !fx_s3_q;
      default:       src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler; its phase survives a ratio change, so no count is lost
  logic [7:0] pre_q;
  logic [7:0] pre_mask;
  logic       cnt_tick;

  always_comb
  begin
    if (ctrl_q.ps > MTM_PS_MAX)
    begin
      pre_mask = MTM_PS_MASK_MAX;
    end
    else
    begin
      pre_mask = 8'((9'h001 << ctrl_q.ps) - 9'h001);
    end
  end

  assign cnt_tick = src_tick && !ctrl_q.halt && ((pre_q & pre_mask) == pre_mask);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_q <= MTM_PRE_RST;
    end
    else if (restart)
    begin
      pre_q <= MTM_PRE_RST;
    end
    else if (src_tick && !ctrl_q.halt)
    begin
      pre_q <= pre_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modulo write buffer
  logic [15:0] mod_q;
  logic [15:0] mod_buf_q;
  logic        modh_pend_q;
  logic        modl_pend_q;
  logic        mod_first_q;
  logic        mod_load;
  logic [15:0] mod_new;

  assign mod_load = (wr_modh && modl_pend_q) || (wr_modl && modh_pend_q);
  assign mod_new  = wr_modh ? {w_data_q, mod_buf_q[7:0]} : {mod_buf_q[15:8], w_data_q};

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mod_q       <= MTM_MOD_RST;
      mod_buf_q   <= MTM_MOD_RST;
      modh_pend_q <= 1'b0;
      modl_pend_q <= 1'b0;
      mod_first_q <= 1'b1;
    end
    else if (restart)
    begin
      modh_pend_q <= 1'b0;
      modl_pend_q <= 1'b0;
    end
    else if (mod_load)
    begin
      mod_q       <= mod_new;
      modh_pend_q <= 1'b0;
      modl_pend_q <= 1'b0;
      mod_first_q <= 1'b0;
    end
    else
    begin
      if (wr_modh)
      begin
        mod_buf_q[15:8] <= w_data_q;
        modh_pend_q     <= 1'b1;
      end
      if (wr_modl)
      begin
        mod_buf_q[7:0] <= w_data_q;
        modl_pend_q    <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main counter
  logic [15:0] cnt_q;
  logic [15:0] cnt_top;
  logic        ovf;

  assign cnt_top = (mod_q == MTM_MOD_RST) ? MTM_CNT_TOP_FREE : mod_q;
  assign ovf     = cnt_tick && (cnt_q == cnt_top) && !restart;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= MTM_CNT_RST;
    end
    else if (restart || (mod_load && mod_first_q))
    begin
      cnt_q <= MTM_CNT_RST;
    end
    else if (cnt_tick)
    begin
      cnt_q <= (cnt_q == cnt_top) ? MTM_CNT_RST : cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel and read side effects
  logic       rd_fire;
  logic [7:0] rd_addr;
  logic       rd_sc;
  logic       rd_cnth;
  logic       rd_cntl;

  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr[7:0];
  assign rd_sc   = rd_fire && (rd_addr == MTM_OFS_SC);
  assign rd_cnth = rd_fire && (rd_addr == MTM_OFS_CNTH);
  assign rd_cntl = rd_fire && (rd_addr == MTM_OFS_CNTL);

  // count coherency latch
  logic [15:0] cnt_buf_q;
  logic        cnt_held_q;
  logic        cnt_hi_first_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_buf_q      <= MTM_CNT_RST;
      cnt_held_q     <= 1'b0;
      cnt_hi_first_q <= 1'b0;
    end
    else if (restart)
    begin
      cnt_held_q <= 1'b0;
    end
    else if ((rd_cnth || rd_cntl) && !cnt_held_q)
    begin
      cnt_buf_q      <= cnt_q;
      cnt_held_q     <= 1'b1;
      cnt_hi_first_q <= rd_cnth;
    end
    else if ((rd_cntl && cnt_hi_first_q) || (rd_cnth && !cnt_hi_first_q))
    begin
      cnt_held_q <= 1'b0;
    end
  end

  // overflow flag with two-step clear
  logic flag_q;
  logic arm_q;
  logic sc_clr_wr;

  assign sc_clr_wr = wr_sc && !w_data_q[MTM_SC_FLAG_BIT];

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      arm_q <= 1'b0;
    end
    else if (ovf || restart || wr_sc)
    begin
      arm_q <= 1'b0;
    end
    else if (rd_sc && flag_q)
    begin
      arm_q <= 1'b1;
    end
  end

  // a fresh overflow beats a clearing write in the same cycle; a restart suppresses the overflow and clears the flag
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag_q <= 1'b0;
    end
    else if (restart)
    begin
      flag_q <= 1'b0;
    end
    else if (ovf)
    begin
      flag_q <= 1'b1;
    end
    else if (sc_clr_wr && arm_q)
    begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      overflow_irq <= 1'b0;
    end
    else
    begin
      overflow_irq <= flag_q && ctrl_q.irq_en;
    end
  end

  logic [7:0] rd_byte;
  logic       rd_ok;

  always_comb
  begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    unique case (rd_addr)
      MTM_OFS_SC:   rd_byte = {flag_q, ctrl_q.irq_en, 1'b0, ctrl_q.halt, 4'h0};
      MTM_OFS_CFG:  rd_byte = {2'b00, ctrl_q.src, ctrl_q.ps};
      MTM_OFS_CNTH: rd_byte = cnt_held_q ? cnt_buf_q[15:8] : cnt_q[15:8];
      MTM_OFS_CNTL: rd_byte = cnt_held_q ? cnt_buf_q[7:0] : cnt_q[7:0];
      MTM_OFS_MODH: rd_byte = mod_q[15:8];
      MTM_OFS_MODL: rd_byte = mod_q[7:0];
      default:      rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= MTM_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_ok ? MTM_RESP_OKAY : MTM_RESP_SLVERR;
    end
    else
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_armed_read;
    rd_sc && flag_q && !ovf && !restart && !wr_sc;
  endsequence

  sequence s_quiet_clear;
    arm_q && sc_clr_wr && !restart && !ovf;
  endsequence

  AST_WRAP: assert property (cnt_tick && !restart && (cnt_q == cnt_top) &&
    !(mod_load && mod_first_q) |=> (cnt_q == 16'h0000) && flag_q)
    else $error("count did not wrap to zero with flag");
  AST_STEP: assert property (cnt_tick && !restart && (cnt_q != cnt_top) &&
    !(mod_load && mod_first_q) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("count did not step by one");
  AST_HALT: assert property (ctrl_q.halt && !restart && !mod_load ##1 ctrl_q.halt
    |-> $stable(cnt_q) && $stable(pre_q))
    else $error("count moved while halted");
  AST_FREE: assert property ((mod_q == 16'h0000) |-> (cnt_top == 16'hFFFF))
    else $error("free-running top is not 0xFFFF");
  AST_ARM: assert property (s_armed_read |=> arm_q)
    else $error("read with flag set did not arm the clear");
  AST_TWO_STEP: assert property (s_quiet_clear |=> !flag_q)
    else $error("armed clear did not clear flag");
  AST_NO_ARM: assert property (flag_q && !arm_q && wr_sc && !restart |=> flag_q)
    else $error("flag cleared without qualifying read");
  AST_CANCEL: assert property (arm_q && ovf |=> !arm_q && flag_q)
    else $error("overflow did not cancel the clear");
  AST_RESTART: assert property (restart |=> !flag_q && (cnt_q == 16'h0000))
    else $error("restart left flag or count");
  AST_IRQ: assert property (##1 overflow_irq == $past(flag_q && ctrl_q.irq_en))
    else $error("interrupt request wrong");
  AST_PS_DEF: assert property ((ctrl_q.ps > 4'h8) |-> (pre_mask == 8'hFF))
    else $error("illegal prescale code not divide by 256");
  AST_MOD_HOLD: assert property ((wr_modh ^ wr_modl) && !mod_load |=> $stable(mod_q))
    else $error("modulo changed on a single byte write");
  AST_LATCH: assert property (rd_cnth && !cnt_held_q && !restart |=> cnt_held_q &&
    (cnt_buf_q == $past(cnt_q)))
    else $error("count byte read did not latch");

endmodule : mtm_modulo_timer

/* File: verification/tb.sv */
// self-checking testbench for the modulo overflow timer
`timescale 1ns/1ns
module tb
  import mtm_pkg::*;
;
  logic        clock;
  logic        sys_rst;
  logic        fixed_freq_clock;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        overflow_irq;
  int          mismatches;
  int          n_checks;

  mtm_modulo_timer mtm_modulo_timer_i (
    .clock(clock), .sys_rst(sys_rst), .fixed_freq_clock(fixed_freq_clock),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .overflow_irq(overflow_irq)
  );

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hang(input string what);
    mismatches++;
    $display("[ERR] %s expected handshake seen none", what);
    summarize();
  endtask : hang

  // master: valids drop at their own take, ready drops after the answer
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    int   n;
    logic aw_ok;
    logic w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200 && !(aw_ok && w_ok && bvalid === 1'b1); n++)
    begin
      @(posedge clock);
      if (!aw_ok && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw_ok = 1;
      end
      if (!w_ok && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w_ok = 1;
      end
    end
    if (n >= 200)
      hang("write");
    resp = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clock);
      if (arready === 1'b1)
        break;
    end
    arvalid <= 1'b0;
    for (n = n; n < 200; n++)
    begin
      @(posedge clock);
      if (rvalid === 1'b1)
        break;
    end
    if (n >= 200)
      hang("read");
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(what, d, exp);
  endtask : rd_chk

  // high byte first latches, low byte read releases
  task automatic cnt_chk(input logic [15:0] exp);
    rd_chk(MTM_OFS_CNTH, {24'h0, exp[15:8]}, "count high");
    rd_chk(MTM_OFS_CNTL, {24'h0, exp[7:0]}, "count low");
  endtask : cnt_chk

  // each phase held 4 clocks, safely above the synchroniser minimum
  task automatic pulse(input int n);
    repeat (n)
    begin
      fixed_freq_clock <= 1'b1;
      repeat (4) @(posedge clock);
      fixed_freq_clock <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(MTM_OFS_SC, 32'h10, "sc reset");
    rd_chk(MTM_OFS_CFG, 32'h00, "cfg reset");
    cnt_chk(16'h0000);
    rd_chk(MTM_OFS_MODH, 32'h00, "modh reset");
    rd_chk(MTM_OFS_MODL, 32'h00, "modl reset");
    axi_rd(8'h18, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, MTM_RESP_SLVERR});
    axi_wr(8'h18, 8'h55, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, MTM_RESP_SLVERR});
    $display("test reset done");
  endtask : t_reset

  task automatic t_prescale();
    int k;
    for (k = 0; k < 10; k++)
    begin
      wr(MTM_OFS_SC, 8'h30);
      wr(MTM_OFS_CFG, 8'h10 | k[7:0]);
      wr(MTM_OFS_SC, 8'h00);
      pulse(2 * ((k > 8) ? 256 : (1 << k)));
      cnt_chk(16'h0002);
    end
    $display("test prescale done");
  endtask : t_prescale

  task automatic t_change();
    wr(MTM_OFS_CFG, 8'h10);
    cnt_chk(16'h0002);
    pulse(3);
    wr(MTM_OFS_CFG, 8'h20);
    rd_chk(MTM_OFS_CFG, 32'h20, "cfg src 10");
    pulse(2);
    wr(MTM_OFS_CFG, 8'h11);
    cnt_chk(16'h0005);
    pulse(4);
    cnt_chk(16'h0007);
    rd_chk(MTM_OFS_CNTL, 32'h07, "count low live");
    pulse(2);
    rd_chk(MTM_OFS_CNTL, 32'h07, "count latched");
    rd_chk(MTM_OFS_CNTH, 32'h00, "count high");
    cnt_chk(16'h0008);
    $display("test change done");
  endtask : t_change

  task automatic t_overflow();
    wr(MTM_OFS_SC, 8'h30);
    wr(MTM_OFS_CFG, 8'h10);
    wr(MTM_OFS_MODL, 8'h03);
    rd_chk(MTM_OFS_MODL, 32'h00, "modl half");
    wr(MTM_OFS_MODH, 8'h00);
    rd_chk(MTM_OFS_MODL, 32'h03, "modl full");
    wr(MTM_OFS_SC, 8'h00);
    pulse(3);
    cnt_chk(16'h0003);
    rd_chk(MTM_OFS_SC, 32'h00, "flag before");
    pulse(1);
    cnt_chk(16'h0000);
    rd_chk(MTM_OFS_SC, 32'h80, "flag at wrap");
    chk("irq masked", {31'h0, overflow_irq}, 32'h0);
    wr(MTM_OFS_SC, 8'h00);
    rd_chk(MTM_OFS_SC, 32'h00, "flag cleared");
    pulse(4);
    wr(MTM_OFS_SC, 8'h00);
    rd_chk(MTM_OFS_SC, 32'h80, "clear unarmed");
    pulse(4);
    wr(MTM_OFS_SC, 8'h00);
    rd_chk(MTM_OFS_SC, 32'h80, "clear cancelled");
    wr(MTM_OFS_SC, 8'h20);
    rd_chk(MTM_OFS_SC, 32'h00, "restart flag");
    cnt_chk(16'h0000);
    wr(MTM_OFS_SC, 8'h40);
    pulse(4);
    chk("irq raised", {31'h0, overflow_irq}, 32'h1);
    rd_chk(MTM_OFS_SC, 32'hC0, "flag irq");
    wr(MTM_OFS_SC, 8'h40);
    repeat (3) @(posedge clock);
    chk("irq dropped", {31'h0, overflow_irq}, 32'h0);
    wr(MTM_OFS_MODH, 8'hFF);
    wr(MTM_OFS_MODL, 8'hFF);
    rd_chk(MTM_OFS_MODH, 32'hFF, "mod top");
    $display("test overflow done");
  endtask : t_overflow

  // bus clock, modulo zero: first wrap needs the full 16-bit range
  task automatic t_freerun();
    int n;
    wr(MTM_OFS_SC, 8'h30);
    wr(MTM_OFS_MODH, 8'h00);
    wr(MTM_OFS_MODL, 8'h00);
    wr(MTM_OFS_CFG, 8'h00);
    wr(MTM_OFS_SC, 8'h40);
    for (n = 0; n < 70000 && overflow_irq !== 1'b1; n++)
      @(posedge clock);
    chk("wrap late", {31'h0, n >= 65525}, 32'h1);
    chk("wrap early", {31'h0, n <= 65545}, 32'h1);
    wr(MTM_OFS_SC, 8'h50);
    rd_chk(MTM_OFS_SC, 32'hD0, "halted flag");
    // four bus ticks pass between the wrap and the halt write landing
    cnt_chk(16'h0004);
    repeat (20) @(posedge clock);
    cnt_chk(16'h0004);
    $display("test freerun done");
  endtask : t_freerun

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    sys_rst = 1'b1;
    fixed_freq_clock = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_prescale();
    t_change();
    t_overflow();
    t_freerun();
    summarize();
  end
endmodule : tb
